// file: include/pmag_map.vh
/*
  Address map, field positions and factory values of the program memory access guard.
  Assumes 22-bit table addresses and byte-wide configuration data.
*/
`ifndef PMAG_MAP_VH
`define PMAG_MAP_VH
`define PMAG_ADDR_W 22
`define PMAG_CFG_READ_LOCK_LO 22'h300008
`define PMAG_CFG_BOOT_DATA_RD 22'h300009
`define PMAG_CFG_WRITE_LOCK_LO 22'h30000a
`define PMAG_CFG_BOOT_DATA_WR 22'h30000b
`define PMAG_CFG_XREAD_LOCK_LO 22'h30000c
`define PMAG_CFG_BOOT_XREAD 22'h30000d
`define PMAG_CFG_DEBUG_PROG 22'h300006
`define PMAG_ID_BASE 22'h200000
`define PMAG_ID_TOP 22'h200007
`define PMAG_DEVID_LO 22'h3ffffe
`define PMAG_DEVID_HI 22'h3fffff
`define PMAG_PROG_TOP 22'h00ffff
`define PMAG_BOOT_TOP 22'h0007ff
`define PMAG_REGION_HI 15
`define PMAG_REGION_LO 14
`define PMAG_REGION_TOP 2'h3
`define PMAG_BIT_DATA 7
`define PMAG_BIT_BOOT 6
`define PMAG_BIT_CFGWR 5
`define PMAG_BIT_LVP 2
`define PMAG_BIT_DEBUG 7
`define PMAG_ERASED 8'hff
`define PMAG_LOW_MASK 8'h0f
`define PMAG_LOW_MASK48 8'h07
`define PMAG_BOOT_RD_MASK 8'hc0
`define PMAG_BOOT_WR_MASK 8'he0
`define PMAG_BOOT_XR_MASK 8'h40
`define PMAG_DBGPROG_MASK 8'h84
`define PMAG_ZERO8 8'h00
`define PMAG_DBG_STACK 2'h2
`define PMAG_DBG_PROG_BYTES 10'h200
`define PMAG_DBG_DATA_BYTES 4'ha
`endif

// file: rtl/pmag_guard.v
/*
  Protection checker for table reads/writes from the CPU and for external programmer
  accesses to program memory, data memory, configuration and ID locations.
  Assumes the memory arrays sit outside; this block grants or refuses each access and
  forces zero read data. Erase requests arrive only from the external programmer port.
*/
`timescale 1ns/1ps
`include "pmag_map.vh"
module pmag_guard #(
  parameter LARGE = 1,
  parameter [15:0] DEVICE_ID = 16'h5a5a  // Arbitrary identification value
) (
  // Clock and reset
  input wire clk,
  input wire rst,
  // CPU table access
  input wire cpu_req,
  input wire cpu_wr,
  input wire [21:0] cpu_addr,
  input wire [21:0] cpu_fetch_addr,
  input wire [7:0] cpu_wdata,
  input wire [7:0] cpu_mem_rdata,
  output reg cpu_grant_q,
  output reg [7:0] cpu_rdata_q,
  // CPU data memory read
  input wire cpu_dm_req,
  output reg cpu_dm_grant_q,
  // External programmer access
  input wire ext_req,
  input wire ext_wr,
  input wire ext_dm,
  input wire [21:0] ext_addr,
  input wire [7:0] ext_wdata,
  input wire [7:0] ext_mem_rdata,
  output reg ext_grant_q,
  output reg [7:0] ext_rdata_q,
  // Programmer erase
  input wire ext_chip_erase,
  input wire ext_block_erase,
  input wire [2:0] ext_erase_region,
  // Programming entry pins
  input wire mclr_high_voltage,
  input wire low_voltage_entry_pin,
  output reg prog_mode_q,
  output reg entry_pin_is_io_q,
  // Debugger reservations
  output reg debug_active_q,
  output reg [1:0] dbg_stack_levels_q,
  output reg [9:0] dbg_prog_bytes_q,
  output reg [3:0] dbg_data_bytes_q,
  output reg dbg_serial_pins_q
);
  // Configuration bytes; erased state is all ones
  reg [7:0] rd_lock_q, bd_rd_q, wr_lock_q, bd_wr_q, xr_lock_q, b_xr_q, dbgprog_q;
  reg [7:0] id_q [0:7];
  reg hv_session_q;
  wire [7:0] low_mask = LARGE ? `PMAG_LOW_MASK : `PMAG_LOW_MASK48;
  integer k;

  // Region decode: 0..3 for regions, 4 for boot
  function [2:0] region_of;
    input [21:0] a;
    begin
      if (a <= `PMAG_BOOT_TOP)
        region_of = 3'h4;
      else
        region_of = {1'b0, a[`PMAG_REGION_HI:`PMAG_REGION_LO]};
    end
  endfunction

  function is_prog;
    input [21:0] a;
    begin
      is_prog = (a <= `PMAG_PROG_TOP) &&
        (LARGE || a[`PMAG_REGION_HI:`PMAG_REGION_LO] != `PMAG_REGION_TOP);
    end
  endfunction

  function is_id;
    input [21:0] a;
    begin
      is_id = (a >= `PMAG_ID_BASE) && (a <= `PMAG_ID_TOP);
    end
  endfunction

  // Per-region bit pick; boot bits live in the high bytes
  function pick;
    input [2:0] r;
    input [7:0] low;
    input boot;
    begin
      pick = r[2] ? boot : low[r[1:0]];
    end
  endfunction

  // Configuration readback, unimplemented bits as zero
  function [7:0] cfg_read;
    input [21:0] a;
    begin
      case (a)
        `PMAG_CFG_READ_LOCK_LO: cfg_read = rd_lock_q & low_mask;
        `PMAG_CFG_BOOT_DATA_RD: cfg_read = bd_rd_q & `PMAG_BOOT_RD_MASK;
        `PMAG_CFG_WRITE_LOCK_LO: cfg_read = wr_lock_q & low_mask;
        `PMAG_CFG_BOOT_DATA_WR: cfg_read = bd_wr_q & `PMAG_BOOT_WR_MASK;
        `PMAG_CFG_XREAD_LOCK_LO: cfg_read = xr_lock_q & low_mask;
        `PMAG_CFG_BOOT_XREAD: cfg_read = b_xr_q & `PMAG_BOOT_XR_MASK;
        `PMAG_CFG_DEBUG_PROG: cfg_read = dbgprog_q & `PMAG_DBGPROG_MASK;
        `PMAG_DEVID_LO: cfg_read = DEVICE_ID[7:0];
        `PMAG_DEVID_HI: cfg_read = DEVICE_ID[15:8];
        default: cfg_read = `PMAG_ZERO8;
      endcase
    end
  endfunction

  function is_cfg;
    input [21:0] a;
    begin
      is_cfg = (a >= `PMAG_CFG_DEBUG_PROG) && (a <= `PMAG_CFG_BOOT_XREAD);
    end
  endfunction

  // CPU side decision
  wire [2:0] cpu_reg = region_of(cpu_addr);
  wire [2:0] cpu_src = region_of(cpu_fetch_addr);
  wire cpu_prog = is_prog(cpu_addr);
  wire cpu_xr = pick(cpu_reg, xr_lock_q, b_xr_q[`PMAG_BIT_BOOT]);
  wire cpu_wl = pick(cpu_reg, wr_lock_q, bd_wr_q[`PMAG_BIT_BOOT]);
  wire cpu_same = is_prog(cpu_fetch_addr) && (cpu_src == cpu_reg);
  wire cpu_rd_ok = cpu_xr || cpu_same;
  wire cfg_wr_open = bd_wr_q[`PMAG_BIT_CFGWR];
  wire cpu_wr_ok = cpu_prog ? cpu_wl :
    is_id(cpu_addr) ? 1'b1 :
    is_cfg(cpu_addr) ? cfg_wr_open : 1'b0;

  // External side decision; access lock only matters here
  wire [2:0] ext_reg = region_of(ext_addr);
  wire ext_prog = is_prog(ext_addr);
  wire ext_cp = pick(ext_reg, rd_lock_q, bd_rd_q[`PMAG_BIT_BOOT]);
  wire ext_wl = pick(ext_reg, wr_lock_q, bd_wr_q[`PMAG_BIT_BOOT]);
  wire dm_open = bd_rd_q[`PMAG_BIT_DATA];
  wire dm_wr_open = bd_wr_q[`PMAG_BIT_DATA];
  wire ext_ok = ext_dm ? (dm_open && (!ext_wr || dm_wr_open)) :
    ext_prog ? (ext_cp && (!ext_wr || ext_wl)) :
    is_id(ext_addr) ? 1'b1 :
    is_cfg(ext_addr) ? (!ext_wr || cfg_wr_open || ext_addr == `PMAG_CFG_BOOT_DATA_WR) :
    !ext_wr;
  wire ext_active = ext_req && prog_mode_q;

  // Programming mode entry
  wire lvp_on = dbgprog_q[`PMAG_BIT_LVP];
  wire enter_hv = mclr_high_voltage;
  wire enter_lv = lvp_on && low_voltage_entry_pin;

  always @(posedge clk) begin
    if (rst) begin
      cpu_grant_q <= 1'b0;
      cpu_rdata_q <= `PMAG_ZERO8;
      cpu_dm_grant_q <= 1'b0;
      ext_grant_q <= 1'b0;
      ext_rdata_q <= `PMAG_ZERO8;
      prog_mode_q <= 1'b0;
      hv_session_q <= 1'b0;
    end else begin
      cpu_dm_grant_q <= cpu_dm_req;
      cpu_grant_q <= cpu_req && (cpu_wr ? cpu_wr_ok : 1'b1);
      if (cpu_req && !cpu_wr) begin
        if (cpu_prog)
          cpu_rdata_q <= cpu_rd_ok ? cpu_mem_rdata : `PMAG_ZERO8;
        else if (is_id(cpu_addr))
          cpu_rdata_q <= id_q[cpu_addr[2:0]];
        else
          cpu_rdata_q <= cfg_read(cpu_addr);
      end
      ext_grant_q <= ext_active && ext_ok;
      if (ext_active && !ext_wr) begin
        if (!ext_ok)
          ext_rdata_q <= `PMAG_ZERO8;
        else if (ext_dm || ext_prog)
          ext_rdata_q <= ext_mem_rdata;
        else if (is_id(ext_addr))
          ext_rdata_q <= id_q[ext_addr[2:0]];
        else
          ext_rdata_q <= cfg_read(ext_addr);
      end
      if (!prog_mode_q && (enter_hv || enter_lv)) begin
        prog_mode_q <= 1'b1;
        hv_session_q <= enter_hv;
      end else if (prog_mode_q && !enter_hv && !enter_lv) begin
        prog_mode_q <= 1'b0;
        hv_session_q <= 1'b0;
      end
    end
  end

  // Configuration and ID storage: lock writes clear only, ID and debug bit writes load the data, LVP bit only from a high-voltage programmer session, erase sets
  wire cpu_w = cpu_req && cpu_wr && cpu_wr_ok;
  wire ext_w = ext_active && ext_wr && ext_ok;
  wire [21:0] w_addr = ext_w ? ext_addr : cpu_addr;
  wire [7:0] w_data = ext_w ? ext_wdata : cpu_wdata;
  wire any_w = ext_w || cpu_w;
  wire [7:0] blk_set = (ext_block_erase && !ext_erase_region[2]) ?
    (`PMAG_ZERO8 | (8'h01 << ext_erase_region[1:0])) : `PMAG_ZERO8;
  wire boot_set = ext_block_erase && ext_erase_region[2];
  // Programmer may clear the config write lock; program writes leave it alone
  wire [7:0] bdw_mask = ext_w ? `PMAG_BOOT_WR_MASK :
    (`PMAG_BOOT_WR_MASK & ~(8'h01 << `PMAG_BIT_CFGWR));

  always @(posedge clk) begin
    if (rst) begin
      dbg_serial_pins_q <= 1'b0;
    end else if (ext_chip_erase && prog_mode_q) begin
      rd_lock_q <= `PMAG_ERASED;
      bd_rd_q <= `PMAG_ERASED;
      wr_lock_q <= `PMAG_ERASED;
      bd_wr_q <= `PMAG_ERASED;
      xr_lock_q <= `PMAG_ERASED;
      b_xr_q <= `PMAG_ERASED;
      dbgprog_q <= `PMAG_ERASED;
      for (k = 0; k < 8; k = k + 1)
        id_q[k] <= `PMAG_ERASED;
    end else if (ext_block_erase && prog_mode_q) begin
      rd_lock_q <= rd_lock_q | blk_set;
      wr_lock_q <= wr_lock_q | blk_set;
      xr_lock_q <= xr_lock_q | blk_set;
      if (boot_set) begin
        bd_rd_q[`PMAG_BIT_BOOT] <= 1'b1;
        bd_wr_q[`PMAG_BIT_BOOT] <= 1'b1;
        b_xr_q[`PMAG_BIT_BOOT] <= 1'b1;
      end
    end else if (any_w) begin
      case (w_addr)
        `PMAG_CFG_READ_LOCK_LO: rd_lock_q <= rd_lock_q & (w_data | ~low_mask);
        `PMAG_CFG_BOOT_DATA_RD: bd_rd_q <= bd_rd_q & (w_data | ~`PMAG_BOOT_RD_MASK);
        `PMAG_CFG_WRITE_LOCK_LO: wr_lock_q <= wr_lock_q & (w_data | ~low_mask);
        `PMAG_CFG_BOOT_DATA_WR: bd_wr_q <= bd_wr_q & (w_data | ~bdw_mask);
        `PMAG_CFG_XREAD_LOCK_LO: xr_lock_q <= xr_lock_q & (w_data | ~low_mask);
        `PMAG_CFG_BOOT_XREAD: b_xr_q <= b_xr_q & (w_data | ~`PMAG_BOOT_XR_MASK);
        `PMAG_CFG_DEBUG_PROG: begin
          dbgprog_q[`PMAG_BIT_DEBUG] <= w_data[`PMAG_BIT_DEBUG];
          if (ext_w && hv_session_q)
            dbgprog_q[`PMAG_BIT_LVP] <= w_data[`PMAG_BIT_LVP];
        end
        default: if (is_id(w_addr)) id_q[w_addr[2:0]] <= w_data;
      endcase
    end
    if (!rst)
      dbg_serial_pins_q <= !dbgprog_q[`PMAG_BIT_DEBUG];
  end

  // Debug reservations and entry pin ownership
  always @(posedge clk) begin
    if (rst) begin
      debug_active_q <= 1'b0;
      dbg_stack_levels_q <= 2'h0;
      dbg_prog_bytes_q <= 10'h000;
      dbg_data_bytes_q <= 4'h0;
      entry_pin_is_io_q <= 1'b0;
    end else begin
      debug_active_q <= !dbgprog_q[`PMAG_BIT_DEBUG];
      dbg_stack_levels_q <= dbgprog_q[`PMAG_BIT_DEBUG] ? 2'h0 : `PMAG_DBG_STACK;
      dbg_prog_bytes_q <= dbgprog_q[`PMAG_BIT_DEBUG] ? 10'h000 :
        `PMAG_DBG_PROG_BYTES;
      dbg_data_bytes_q <= dbgprog_q[`PMAG_BIT_DEBUG] ? 4'h0 : `PMAG_DBG_DATA_BYTES;
      entry_pin_is_io_q <= !lvp_on;
    end
  end

  // Power-up contents stand for an erased part
  initial begin
    rd_lock_q = `PMAG_ERASED;
    bd_rd_q = `PMAG_ERASED;
    wr_lock_q = `PMAG_ERASED;
    bd_wr_q = `PMAG_ERASED;
    xr_lock_q = `PMAG_ERASED;
    b_xr_q = `PMAG_ERASED;
    dbgprog_q = `PMAG_ERASED;
    for (k = 0; k < 8; k = k + 1)
      id_q[k] = `PMAG_ERASED;
  end
endmodule // pmag_guard

// file: sim/pmag_mem.sv
/*
  Memory array model on the far side of the guard: one byte per address.
  Assumes the guard samples array data in the request cycle.
*/
`timescale 1ns/1ps
module pmag_mem (
  // Addresses
  input wire [21:0] cpu_addr,
  input wire [21:0] ext_addr,
  // Array data
  output wire [7:0] cpu_mem_rdata,
  output wire [7:0] ext_mem_rdata
);
  // Address-dependent pattern, so a stale byte passes for fresh only from an address with the same addr[7:0] ^ addr[15:8]
  assign cpu_mem_rdata = cpu_addr[7:0] ^ cpu_addr[15:8] ^ 8'ha5;
  assign ext_mem_rdata = ext_addr[7:0] ^ ext_addr[15:8] ^ 8'ha5;
endmodule // pmag_mem

// file: sim/pmag_guard_chk.sv
/*
  Port-level assertions for the access guard.
  Assumes one clock domain and a synchronous active-high reset.
*/
`timescale 1ns/1ps
module pmag_guard_chk (
  // Clock and reset
  input wire clk,
  input wire rst,
  // CPU side
  input wire cpu_req,
  input wire cpu_wr,
  input wire cpu_grant_q,
  input wire cpu_dm_req,
  input wire cpu_dm_grant_q,
  // Programmer side
  input wire ext_req,
  input wire ext_wr,
  input wire ext_grant_q,
  input wire [7:0] ext_rdata_q,
  // Entry and debug
  input wire mclr_high_voltage,
  input wire low_voltage_entry_pin,
  input wire prog_mode_q,
  input wire entry_pin_is_io_q,
  input wire debug_active_q,
  input wire [1:0] dbg_stack_levels_q,
  input wire [9:0] dbg_prog_bytes_q,
  input wire [3:0] dbg_data_bytes_q,
  input wire dbg_serial_pins_q
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_dm_grant; cpu_dm_req |=> cpu_dm_grant_q; endproperty
  a_dm_grant: assert property (p_dm_grant) else $error("cpu data read not granted");
  property p_rd_grant; cpu_req && !cpu_wr |=> cpu_grant_q; endproperty
  a_rd_grant: assert property (p_rd_grant) else $error("table read not granted");
  property p_grant_cause; cpu_grant_q |-> $past(cpu_req); endproperty
  a_grant_cause: assert property (p_grant_cause) else $error("grant without request");
  property p_ext_idle; ext_req && !prog_mode_q |=> !ext_grant_q; endproperty
  a_ext_idle: assert property (p_ext_idle) else $error("ext grant outside prog");
  property p_ext_zero;
    !ext_grant_q && $past(ext_req && prog_mode_q && !ext_wr) |-> ext_rdata_q == 8'h00;
  endproperty
  a_ext_zero: assert property (p_ext_zero) else $error("refused ext read not zero");
  property p_hv_entry; mclr_high_voltage |=> prog_mode_q; endproperty
  a_hv_entry: assert property (p_hv_entry) else $error("high voltage entry lost");
  property p_lv_entry; !entry_pin_is_io_q && low_voltage_entry_pin |=> prog_mode_q; endproperty
  a_lv_entry: assert property (p_lv_entry) else $error("low voltage entry lost");
  property p_pin_io; entry_pin_is_io_q && !mclr_high_voltage |=> !prog_mode_q; endproperty
  a_pin_io: assert property (p_pin_io) else $error("entry pin not plain io");
  property p_dbg;
    debug_active_q |-> dbg_stack_levels_q == 2'h2 && dbg_prog_bytes_q == 10'h200
      && dbg_data_bytes_q == 4'ha && dbg_serial_pins_q;
  endproperty
  a_dbg: assert property (p_dbg) else $error("debug reservation wrong");
endmodule // pmag_guard_chk
bind pmag_guard pmag_guard_chk pmag_guard_chk_i (.*);

// file: sim/program_memory_access_guard_bench.sv
/*
  Self-checking bench for the access guard with a memory array model.
  Assumes the one-cycle grant timing of the hand-over contract.
*/
`timescale 1ns/1ps
`include "pmag_map.vh"
module program_memory_access_guard_bench;
  reg clk = 0, rst = 1, cpu_req = 0, cpu_wr = 0, cpu_dm_req = 0, ext_req = 0, ext_wr = 0;
  reg ext_dm = 0, ext_chip_erase = 0, ext_block_erase = 0, mclr_high_voltage = 0;
  reg low_voltage_entry_pin = 0, cpu_seen = 0, ext_seen = 0;
  reg [21:0] cpu_addr = 0, cpu_fetch_addr = 0, ext_addr = 0, r;
  reg [7:0] cpu_wdata = 0, ext_wdata = 0, d;
  reg [2:0] ext_erase_region = 0;
  wire [7:0] cpu_mem_rdata, ext_mem_rdata, cpu_rdata_q, ext_rdata_q;
  wire cpu_grant_q, cpu_dm_grant_q, ext_grant_q, prog_mode_q, entry_pin_is_io_q;
  wire debug_active_q, dbg_serial_pins_q;
  wire [1:0] dbg_stack_levels_q;
  wire [9:0] dbg_prog_bytes_q;
  wire [3:0] dbg_data_bytes_q;
  integer num_errors = 0, samples_checked = 0, i;
  reg [9:0] cq[$], eq[$];
  reg [7:0] msk [0:5] = '{8'h0f, 8'hc0, 8'h0f, 8'he0, 8'h0f, 8'h40};
  pmag_mem pmag_mem_i (.cpu_addr(cpu_addr), .ext_addr(ext_addr),
    .cpu_mem_rdata(cpu_mem_rdata), .ext_mem_rdata(ext_mem_rdata));
  pmag_guard #(.LARGE(1), .DEVICE_ID(16'h3c96)) pmag_guard_i (.clk(clk), .rst(rst),
    .cpu_req(cpu_req), .cpu_wr(cpu_wr), .cpu_addr(cpu_addr), .cpu_fetch_addr(cpu_fetch_addr),
    .cpu_wdata(cpu_wdata), .cpu_mem_rdata(cpu_mem_rdata), .cpu_grant_q(cpu_grant_q),
    .cpu_rdata_q(cpu_rdata_q), .cpu_dm_req(cpu_dm_req), .cpu_dm_grant_q(cpu_dm_grant_q),
    .ext_req(ext_req), .ext_wr(ext_wr), .ext_dm(ext_dm), .ext_addr(ext_addr),
    .ext_wdata(ext_wdata), .ext_mem_rdata(ext_mem_rdata), .ext_grant_q(ext_grant_q),
    .ext_rdata_q(ext_rdata_q), .ext_chip_erase(ext_chip_erase),
    .ext_block_erase(ext_block_erase), .ext_erase_region(ext_erase_region),
    .mclr_high_voltage(mclr_high_voltage), .low_voltage_entry_pin(low_voltage_entry_pin),
    .prog_mode_q(prog_mode_q), .entry_pin_is_io_q(entry_pin_is_io_q),
    .debug_active_q(debug_active_q), .dbg_stack_levels_q(dbg_stack_levels_q),
    .dbg_prog_bytes_q(dbg_prog_bytes_q), .dbg_data_bytes_q(dbg_data_bytes_q),
    .dbg_serial_pins_q(dbg_serial_pins_q));
  function [7:0] md(input [21:0] a);
    md = a[7:0] ^ a[15:8] ^ 8'ha5;
  endfunction
  task check(input string n, input [8:0] s, input [8:0] e);
    samples_checked = samples_checked + 1;
    if (s !== e) begin
      num_errors = num_errors + 1;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  // Note: {compare data, grant, data}; write data checks are grant only
  task cpu(input w, input [21:0] a, f, input [7:0] wd, input g, c, input [7:0] rd);
    ext_req = 0; cpu_req = 1; cpu_wr = w; cpu_addr = a; cpu_fetch_addr = f; cpu_wdata = wd;
    cq.push_back({c, g, c ? rd : 8'h00});
    @(negedge clk);
  endtask
  task ext(input w, m, input [21:0] a, input [7:0] wd, input g, c, input [7:0] rd);
    cpu_req = 0; ext_req = 1; ext_wr = w; ext_dm = m; ext_addr = a; ext_wdata = wd;
    eq.push_back({c, g, c ? rd : 8'h00});
    @(negedge clk);
  endtask
  // Idle cycle lets a config update land before it is read back
  task idle;
    cpu_req = 0; ext_req = 0;
    @(negedge clk);
  endtask
  task results;
    $display("Checked %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge clk) begin
    cpu_seen <= cpu_req;
    ext_seen <= ext_req && prog_mode_q;
  end
  always @(negedge clk) begin
    if (cpu_seen && cq.size() > 0) begin
      r = cq.pop_front();
      check("cpu", {cpu_grant_q, r[9] ? cpu_rdata_q : 8'h00}, r[8:0]);
    end
    if (ext_seen && eq.size() > 0) begin
      r = eq.pop_front();
      check("ext", {ext_grant_q, r[9] ? ext_rdata_q : 8'h00}, r[8:0]);
    end
  end
  initial begin
    forever #2.5 clk = ~clk;
  end
  initial begin
    d = $urandom(32'h770ffc62);
    repeat (10) @(negedge clk);
    rst = 0;
    @(negedge clk);
    for (i = 0; i < 6; i++) cpu(0, 22'h300008 + i, 0, 0, 1, 1, msk[i]);
    cpu(0, `PMAG_CFG_DEBUG_PROG, 0, 0, 1, 1, `PMAG_DBGPROG_MASK);
    cpu(0, `PMAG_DEVID_LO, 0, 0, 1, 1, 8'h96);
    cpu(0, `PMAG_DEVID_HI, 0, 0, 1, 1, 8'h3c);
    cpu(1, `PMAG_CFG_XREAD_LOCK_LO, 0, 8'hfd, 1, 0, 0);
    idle;
    cpu(0, 22'h4010, 22'h0100, 0, 1, 1, 8'h00);
    cpu(0, 22'h4010, 22'h7ffe, 0, 1, 1, md(22'h4010));
    cpu(0, 22'h4010, 22'h3fff, 0, 1, 1, 8'h00);
    cpu(1, `PMAG_CFG_XREAD_LOCK_LO, 0, 8'hff, 1, 0, 0);
    idle;
    cpu(0, `PMAG_CFG_XREAD_LOCK_LO, 0, 0, 1, 1, 8'h0d);
    cpu(1, `PMAG_CFG_WRITE_LOCK_LO, 0, 8'hfb, 1, 0, 0);
    cpu(1, `PMAG_CFG_BOOT_DATA_WR, 0, 8'h9f, 1, 0, 0);
    idle;
    d = $urandom;
    r = 22'h8000 | ($urandom & 22'h3fff);
    cpu(1, r, 0, d, 0, 0, 0);
    cpu(1, 22'h7fff, 0, d, 1, 0, 0);
    cpu(0, `PMAG_CFG_BOOT_DATA_WR, 0, 0, 1, 1, 8'ha0);
    cpu(1, `PMAG_BOOT_TOP, 0, d, 0, 0, 0);
    cpu(1, 22'h0800, 0, d, 1, 0, 0);
    cpu(1, `PMAG_ID_TOP, 0, d, 1, 0, 0);
    idle;
    $display("Table locks done");
    low_voltage_entry_pin = 1;
    repeat (2) @(negedge clk);
    check("lv entry", {8'h00, prog_mode_q}, 9'h001);
    // Leave the low-voltage session so the next entry counts as high voltage
    low_voltage_entry_pin = 0;
    @(negedge clk);
    mclr_high_voltage = 1;
    cpu_dm_req = 1;
    @(negedge clk);
    ext(0, 0, 22'h1000, 0, 1, 1, md(22'h1000));
    cpu(1, `PMAG_CFG_READ_LOCK_LO, 0, 8'hfe, 1, 0, 0);
    idle;
    ext(0, 0, 22'h1000, 0, 0, 1, 8'h00);
    cpu(0, 22'h1000, 22'h8000, 0, 1, 1, md(22'h1000));
    ext(0, 0, `PMAG_ID_BASE, 0, 1, 0, 0);
    ext(1, 1, 22'h0010, d, 1, 0, 0);
    ext(1, 0, `PMAG_CFG_BOOT_DATA_WR, 8'h7f, 1, 0, 0);
    idle;
    ext(1, 1, 22'h0010, d, 0, 0, 0);
    ext(0, 1, 22'h0010, 0, 1, 1, md(22'h0010));
    ext(1, 0, `PMAG_CFG_BOOT_DATA_RD, 8'h7f, 1, 0, 0);
    idle;
    ext(0, 1, 22'h0010, 0, 0, 1, 8'h00);
    cpu_dm_req = 0;
    ext_chip_erase = 1;
    @(negedge clk);
    ext_chip_erase = 0;
    idle;
    cpu(0, `PMAG_CFG_READ_LOCK_LO, 0, 0, 1, 1, 8'h0f);
    cpu(1, `PMAG_CFG_BOOT_XREAD, 0, 8'h00, 1, 0, 0);
    ext_block_erase = 1;
    ext_erase_region = 3'h4;
    @(negedge clk);
    ext_block_erase = 0;
    idle;
    cpu(0, `PMAG_CFG_BOOT_XREAD, 0, 0, 1, 1, 8'h40);
    ext(1, 0, `PMAG_CFG_DEBUG_PROG, 8'h7b, 1, 0, 0);
    idle;
    check("pin io", {8'h00, entry_pin_is_io_q}, 9'h001);
    check("debug", {8'h00, debug_active_q}, 9'h001);
    mclr_high_voltage = 0;
    low_voltage_entry_pin = 1;
    repeat (2) @(negedge clk);
    check("no lv entry", {8'h00, prog_mode_q}, 9'h000);
    $display("Programmer path done");
    results;
  end
endmodule // program_memory_access_guard_bench
